// [rtl/pcs_map.svh]
// Constants for the program counter sequencer: vectors, stack, opcode map, timing.
// Assumes byte-wide program/data memory with 16-bit addresses.
// Contract
// RULE1: Sixteen-bit counter holds next memory address
// RULE2: Jump loads counter with instruction target
// RULE3: Accepted interrupt loads its vector address
// RULE4: Both returns reload counter from stack
// RULE5: Subroutine invoke loads subroutine start address
// RULE6: Reset sets counter to reset vector
// RULE7: Sequential flow advances by instruction length
// RULE8: 107 opcodes, cycle count varies per opcode
// RULE9: Execution clocked directly by undivided masterclock
// RULE10: Five decode parts: load, alu, jump, control, fuzzy
// RULE11: Arbiter activates one part at most
// RULE12: Collector merges part controls into outputs
// RULE13: Accumulator hidden; operands are register addresses
// RULE14: Five addressing modes supported
// RULE15: External reset re-initialises state, mode switching
// RULE16: Select pin high programming, low working
// RULE17: Locations zero to two are reset vector
// RULE18: Vector entries are three bytes each
// RULE19: Call/interrupt push counter, pointer minus two
// RULE20: Return: pointer plus two, then restore
// RULE21: Hold reset vector, fetch after release
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_RESET_VEC 16'h0000
`define PCS_VEC_BASE 16'h0003
`define PCS_VEC_STRIDE 16'h0003
`define PCS_SSP_RESET 16'h20ff
`define PCS_STACK_STEP 16'h0002
`define PCS_INSTR_COUNT 8'h6b

`define PCS_LOAD_LO 8'h00
`define PCS_LOAD_HI 8'h1f
`define PCS_ALU_LO 8'h20
`define PCS_ALU_HI 8'h3f
`define PCS_JUMP_LO 8'h40
`define PCS_JUMP_HI 8'h4f
`define PCS_CTL_LO 8'h50
`define PCS_CTL_HI 8'h5f
`define PCS_FUZ_LO 8'h60
`define PCS_FUZ_HI 8'h6a

`define PCS_OP_JP 8'h40
`define PCS_OP_CALL 8'h41
`define PCS_OP_RET 8'h42
`define PCS_OP_INTERRUPT_EXIT 8'h43

`define PCS_CYC_LOAD 4'h1
`define PCS_CYC_ALU 4'h2
`define PCS_CYC_JUMP 4'h1
`define PCS_CYC_CTL 4'h1
`define PCS_CYC_FUZ 4'h4

`define PCS_DEST_DPU 3'h1
`define PCS_DEST_DEC 3'h2
`define PCS_DEST_PER 3'h4

`endif

// [rtl/pcs_pkg.sv]
// Types for the program counter sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pcs_pkg;
	typedef enum logic [10:0] {
		PCS_ST_FETCH = 11'h001,
		PCS_ST_OPC = 11'h002,
		PCS_ST_ARG1 = 11'h004,
		PCS_ST_ARG2 = 11'h008,
		PCS_ST_EXEC = 11'h010,
		PCS_ST_PUSH1 = 11'h020,
		PCS_ST_PUSH2 = 11'h040,
		PCS_ST_POP1 = 11'h080,
		PCS_ST_POP2 = 11'h100,
		PCS_ST_POP3 = 11'h200,
		PCS_ST_SPARE = 11'h400
	} pcs_state_t;

	typedef enum logic [2:0] {
		PCS_AM_INH = 3'h0,
		PCS_AM_IMM = 3'h1,
		PCS_AM_DIR = 3'h2,
		PCS_AM_IND = 3'h3,
		PCS_AM_BIT = 3'h4
	} pcs_mode_t;
endpackage

// [rtl/pcs_dec_part.sv]
// One decode part of the control unit: opcode range match, length, cycles, controls.
// Assumes the arbiter in the parent grants at most one part.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_dec_part #(
	parameter logic [7:0] OP_LO = 8'h00,
	parameter logic [7:0] OP_HI = 8'h1f,
	parameter logic [3:0] BASE_CYC = 4'h1,
	parameter logic [2:0] DEST = 3'h1,
	parameter bit JUMP = 1'b0
) (
	input wire logic [7:0] opcode,
	input wire logic grant,
	output logic hit,
	output logic [1:0] len,
	output logic [3:0] cyc,
	output pcs_pkg::pcs_mode_t mode,
	output logic [7:0] ctrl_dpu,
	output logic [7:0] ctrl_dec,
	output logic [7:0] ctrl_per
);
	import pcs_pkg::*;

	always_comb begin
		hit = (opcode >= OP_LO) && (opcode <= OP_HI) && (opcode < `PCS_INSTR_COUNT); // RULE8
		case (opcode[2:0]) // RULE14
			3'h1: mode = PCS_AM_IMM;
			3'h2: mode = PCS_AM_DIR;
			3'h3: mode = PCS_AM_IND;
			3'h4: mode = PCS_AM_BIT;
			default: mode = PCS_AM_INH;
		endcase
		case (mode)
			PCS_AM_INH: len = 2'h1;
			PCS_AM_BIT: len = 2'h3;
			default: len = 2'h2;
		endcase
		if (JUMP) begin
			// Returns carry no operand, jumps carry a 16-bit target
			mode = opcode[1] ? PCS_AM_INH : PCS_AM_DIR;
			len = opcode[1] ? 2'h1 : 2'h3;
		end
		cyc = BASE_CYC + {2'h0, len}; // RULE8
		ctrl_dpu = (grant && DEST[0]) ? opcode : 8'h00; // RULE12
		ctrl_dec = (grant && DEST[1]) ? opcode : 8'h00;
		ctrl_per = (grant && DEST[2]) ? opcode : 8'h00;
	end
endmodule // pcs_dec_part

// [rtl/pcs_core.sv]
// Program counter sequencer: fetch, decode arbitration, collector, next-address selection.
// Assumes memory read data is valid the cycle after mem_rd; writes take effect on the edge.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_core (
	input wire logic clk,
	input wire logic nrst,
	input wire logic prog_mode,
	input wire logic irq_req,
	input wire logic [2:0] irq_idx,
	output logic irq_ack,
	output logic irq_exit,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic [15:0] next_address_counter,
	output logic [15:0] call_stack_pointer,
	output logic ctrl_vld,
	output logic [7:0] ctrl_dpu,
	output logic [7:0] ctrl_dec,
	output logic [7:0] ctrl_per,
	output logic [7:0] opnd_addr,
	output logic [7:0] opnd_aux,
	output pcs_pkg::pcs_mode_t addr_mode
);
	import pcs_pkg::*;

	localparam int NPART = 5;
	localparam logic [7:0] PART_LO [NPART] = '{`PCS_LOAD_LO, `PCS_ALU_LO, `PCS_JUMP_LO, `PCS_CTL_LO, `PCS_FUZ_LO};
	localparam logic [7:0] PART_HI [NPART] = '{`PCS_LOAD_HI, `PCS_ALU_HI, `PCS_JUMP_HI, `PCS_CTL_HI, `PCS_FUZ_HI};
	localparam logic [3:0] PART_CYC [NPART] = '{`PCS_CYC_LOAD, `PCS_CYC_ALU, `PCS_CYC_JUMP, `PCS_CYC_CTL,
		`PCS_CYC_FUZ};
	localparam logic [2:0] PART_DEST [NPART] = '{`PCS_DEST_DPU, `PCS_DEST_DPU, `PCS_DEST_DPU, `PCS_DEST_PER,
		`PCS_DEST_DEC};

	pcs_state_t state_r, state_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] ssp_r, ssp_nxt;
	logic [15:0] tgt_r, tgt_nxt;
	logic [7:0] opcode_r, opcode_nxt;
	logic [7:0] arg1_r, arg1_nxt;
	logic [7:0] arg2_r, arg2_nxt;
	logic [7:0] hold_r, hold_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic interrupt_exit_r, interrupt_exit_nxt;
	logic irq_exit_r, irq_exit_nxt;
	logic ctrl_vld_r, ctrl_vld_nxt;
	logic [7:0] ctrl_dpu_r, ctrl_dpu_nxt;
	logic [7:0] ctrl_dec_r, ctrl_dec_nxt;
	logic [7:0] ctrl_per_r, ctrl_per_nxt;
	pcs_mode_t mode_r, mode_nxt;

	logic [7:0] dec_op;
	logic [NPART-1:0] hits;
	logic [NPART-1:0] grant;
	logic [1:0] part_len [NPART];
	logic [3:0] part_cyc [NPART];
	pcs_mode_t part_mode [NPART];
	logic [7:0] part_dpu [NPART];
	logic [7:0] part_dec [NPART];
	logic [7:0] part_per [NPART];
	logic [1:0] sel_len;
	logic [3:0] sel_cyc;
	pcs_mode_t sel_mode;
	logic [7:0] col_dpu, col_dec, col_per;
	logic [15:0] vec_addr;
	logic exec_end;

	// --------------------------------------------------------------
	// Decode parts, arbiter and collector
	// --------------------------------------------------------------
	assign dec_op = (state_r == PCS_ST_OPC) ? mem_rdata : opcode_r;

	genvar g;
	generate
		for (g = 0; g < NPART; g++) begin : g_part
			pcs_dec_part #(
				.OP_LO(PART_LO[g]),
				.OP_HI(PART_HI[g]),
				.BASE_CYC(PART_CYC[g]),
				.DEST(PART_DEST[g]),
				.JUMP(g == 2)
			) u_part ( // RULE10
				.opcode(dec_op),
				.grant(grant[g]),
				.hit(hits[g]),
				.len(part_len[g]),
				.cyc(part_cyc[g]),
				.mode(part_mode[g]),
				.ctrl_dpu(part_dpu[g]),
				.ctrl_dec(part_dec[g]),
				.ctrl_per(part_per[g])
			);
		end
	endgenerate

	always_comb begin
		// Lowest matching part wins; nothing is granted in programming mode
		grant = prog_mode ? '0 : (hits & (~hits + 5'h01)); // RULE11 RULE16
		sel_len = 2'h1;
		sel_cyc = 4'h1;
		sel_mode = PCS_AM_INH;
		col_dpu = 8'h00;
		col_dec = 8'h00;
		col_per = 8'h00;
		for (int i = 0; i < NPART; i++) begin
			if (grant[i]) begin
				sel_len = part_len[i];
				sel_cyc = part_cyc[i];
				sel_mode = part_mode[i];
			end
			col_dpu = col_dpu | part_dpu[i]; // RULE12
			col_dec = col_dec | part_dec[i];
			col_per = col_per | part_per[i];
		end
	end

	// Each vector entry is a three-byte jump starting after the reset vector
	assign vec_addr = `PCS_VEC_BASE + `PCS_VEC_STRIDE * {13'h0000, irq_idx}; // RULE18 RULE17
	assign exec_end = (state_r == PCS_ST_EXEC) && (cnt_r == 4'h0);

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		ssp_nxt = ssp_r;
		tgt_nxt = tgt_r;
		opcode_nxt = opcode_r;
		arg1_nxt = arg1_r;
		arg2_nxt = arg2_r;
		hold_nxt = hold_r;
		cnt_nxt = cnt_r;
		interrupt_exit_nxt = interrupt_exit_r;
		mode_nxt = mode_r;
		irq_exit_nxt = 1'b0;
		ctrl_vld_nxt = 1'b0;
		ctrl_dpu_nxt = ctrl_dpu_r;
		ctrl_dec_nxt = ctrl_dec_r;
		ctrl_per_nxt = ctrl_per_r;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_addr = pc_r; // RULE1
		mem_wdata = 8'h00;
		irq_ack = 1'b0;
		case (state_r)
			PCS_ST_FETCH: begin
				if (prog_mode) begin
					state_nxt = PCS_ST_FETCH; // RULE16
				end else if (irq_req) begin
					irq_ack = 1'b1;
					tgt_nxt = vec_addr; // RULE3
					state_nxt = PCS_ST_PUSH1;
				end else begin
					mem_rd = 1'b1;
					state_nxt = PCS_ST_OPC;
				end
			end
			PCS_ST_OPC: begin
				opcode_nxt = mem_rdata;
				mode_nxt = sel_mode; // RULE14
				pc_nxt = pc_r + 16'h0001; // RULE7
				cnt_nxt = sel_cyc - 4'h1; // RULE8
				if (sel_len != 2'h1) begin
					mem_rd = 1'b1;
					mem_addr = pc_r + 16'h0001;
					state_nxt = PCS_ST_ARG1;
				end else begin
					state_nxt = PCS_ST_EXEC;
				end
			end
			PCS_ST_ARG1: begin
				arg1_nxt = mem_rdata;
				pc_nxt = pc_r + 16'h0001; // RULE7
				if (sel_len == 2'h3) begin
					mem_rd = 1'b1;
					mem_addr = pc_r + 16'h0001;
					state_nxt = PCS_ST_ARG2;
				end else begin
					state_nxt = PCS_ST_EXEC;
				end
			end
			PCS_ST_ARG2: begin
				arg2_nxt = mem_rdata;
				pc_nxt = pc_r + 16'h0001; // RULE7
				state_nxt = PCS_ST_EXEC;
			end
			PCS_ST_EXEC: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0) begin
					cnt_nxt = 4'h0;
					ctrl_vld_nxt = 1'b1; // RULE12
					ctrl_dpu_nxt = col_dpu;
					ctrl_dec_nxt = col_dec;
					ctrl_per_nxt = col_per;
					state_nxt = PCS_ST_FETCH;
					case (opcode_r)
						`PCS_OP_JP: pc_nxt = {arg1_r, arg2_r}; // RULE2
						`PCS_OP_CALL: begin
							tgt_nxt = {arg1_r, arg2_r}; // RULE5
							state_nxt = PCS_ST_PUSH1;
						end
						`PCS_OP_RET, `PCS_OP_INTERRUPT_EXIT: begin
							interrupt_exit_nxt = (opcode_r == `PCS_OP_INTERRUPT_EXIT);
							state_nxt = PCS_ST_POP1;
						end
						default: state_nxt = PCS_ST_FETCH;
					endcase
				end
			end
			PCS_ST_PUSH1: begin
				mem_wr = 1'b1;
				mem_addr = ssp_r; // RULE19
				mem_wdata = pc_r[15:8];
				state_nxt = PCS_ST_PUSH2;
			end
			PCS_ST_PUSH2: begin
				mem_wr = 1'b1;
				mem_addr = ssp_r - 16'h0001;
				mem_wdata = pc_r[7:0];
				ssp_nxt = ssp_r - `PCS_STACK_STEP; // RULE19
				pc_nxt = tgt_r; // RULE3 RULE5
				state_nxt = PCS_ST_FETCH;
			end
			PCS_ST_POP1: begin
				mem_rd = 1'b1;
				mem_addr = ssp_r + `PCS_STACK_STEP; // RULE20
				state_nxt = PCS_ST_POP2;
			end
			PCS_ST_POP2: begin
				hold_nxt = mem_rdata;
				mem_rd = 1'b1;
				mem_addr = ssp_r + 16'h0001;
				state_nxt = PCS_ST_POP3;
			end
			PCS_ST_POP3: begin
				pc_nxt = {hold_r, mem_rdata}; // RULE4
				ssp_nxt = ssp_r + `PCS_STACK_STEP; // RULE20
				irq_exit_nxt = interrupt_exit_r;
				state_nxt = PCS_ST_FETCH;
			end
			default: state_nxt = PCS_ST_FETCH;
		endcase
		// No memory traffic while reset is held
		if (!nrst) begin
			mem_rd = 1'b0; // RULE21
			mem_wr = 1'b0;
			irq_ack = 1'b0;
		end
	end

	// Runs straight off the core clock, no divider
	always_ff @(posedge clk) begin // RULE9
		if (!nrst) begin // RULE15
			state_r <= PCS_ST_FETCH;
			pc_r <= `PCS_RESET_VEC; // RULE6 RULE21
			ssp_r <= `PCS_SSP_RESET;
			tgt_r <= 16'h0000;
			opcode_r <= 8'h00;
			arg1_r <= 8'h00;
			arg2_r <= 8'h00;
			hold_r <= 8'h00;
			cnt_r <= 4'h0;
			interrupt_exit_r <= 1'b0;
			mode_r <= PCS_AM_INH;
			irq_exit_r <= 1'b0;
			ctrl_vld_r <= 1'b0;
			ctrl_dpu_r <= 8'h00;
			ctrl_dec_r <= 8'h00;
			ctrl_per_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			ssp_r <= ssp_nxt;
			tgt_r <= tgt_nxt;
			opcode_r <= opcode_nxt;
			arg1_r <= arg1_nxt;
			arg2_r <= arg2_nxt;
			hold_r <= hold_nxt;
			cnt_r <= cnt_nxt;
			interrupt_exit_r <= interrupt_exit_nxt;
			mode_r <= mode_nxt;
			irq_exit_r <= irq_exit_nxt;
			ctrl_vld_r <= ctrl_vld_nxt;
			ctrl_dpu_r <= ctrl_dpu_nxt;
			ctrl_dec_r <= ctrl_dec_nxt;
			ctrl_per_r <= ctrl_per_nxt;
		end
	end

	assign next_address_counter = pc_r; // RULE1
	assign call_stack_pointer = ssp_r;
	assign irq_exit = irq_exit_r;
	assign ctrl_vld = ctrl_vld_r;
	assign ctrl_dpu = ctrl_dpu_r;
	assign ctrl_dec = ctrl_dec_r;
	assign ctrl_per = ctrl_per_r;
	// Operands are register file addresses; the accumulator never leaves the core
	assign opnd_addr = arg1_r; // RULE13
	assign opnd_aux = arg2_r;
	assign addr_mode = mode_r;

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_push;
		state_r == PCS_ST_PUSH1 ##1 state_r == PCS_ST_PUSH2;
	endsequence

	sequence s_pop;
		state_r == PCS_ST_POP1 ##1 state_r == PCS_ST_POP2 ##1 state_r == PCS_ST_POP3;
	endsequence

	property p_reset_vec;
		disable iff (1'b0) !nrst |=> pc_r == `PCS_RESET_VEC && state_r == PCS_ST_FETCH;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("counter not at reset vector after reset"); // RULE6

	property p_reset_quiet;
		disable iff (1'b0) !nrst |-> !mem_rd && !mem_wr && !irq_ack;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("memory access during reset"); // RULE21

	property p_jump;
		exec_end && opcode_r == `PCS_OP_JP |=> pc_r == {$past(arg1_r), $past(arg2_r)} && state_r == PCS_ST_FETCH;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded"); // RULE2

	property p_call;
		exec_end && opcode_r == `PCS_OP_CALL |=> s_push ##1 pc_r == {arg1_r, arg2_r};
	endproperty
	a_call: assert property (p_call) else $error("call did not push then load start address"); // RULE5

	property p_irq;
		irq_ack |=> s_push ##1 pc_r == $past(vec_addr, 3);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt vector not loaded"); // RULE3

	property p_push_ssp;
		state_r == PCS_ST_PUSH2 |-> mem_wr ##1 ssp_r == $past(ssp_r) - 16'h0002;
	endproperty
	a_push_ssp: assert property (p_push_ssp) else $error("stack pointer not decreased by two"); // RULE19

	property p_ret;
		exec_end && (opcode_r == `PCS_OP_RET || opcode_r == `PCS_OP_INTERRUPT_EXIT) |=> s_pop ##1
			ssp_r == $past(ssp_r, 4) + 16'h0002;
	endproperty
	a_ret: assert property (p_ret) else $error("return did not pop and raise pointer by two"); // RULE20

	property p_pop_pc;
		state_r == PCS_ST_POP3 |=> pc_r == {$past(hold_r), $past(mem_rdata)};
	endproperty
	a_pop_pc: assert property (p_pop_pc) else $error("counter not restored from stack"); // RULE4

	property p_one_part;
		$onehot0(grant) && ((grant & ~hits) == 5'h00) && (prog_mode || (hits == 5'h00) || (grant != 5'h00));
	endproperty
	a_one_part: assert property (p_one_part) else $error("more than one decode part active"); // RULE11

	property p_advance;
		state_r == PCS_ST_OPC |=> pc_r == $past(pc_r) + 16'h0001;
	endproperty
	a_advance: assert property (p_advance) else $error("counter did not advance on opcode byte"); // RULE7

	property p_exec_end;
		exec_end |=> ctrl_vld_r && state_r != PCS_ST_EXEC;
	endproperty
	a_exec_end: assert property (p_exec_end) else $error("execute phase did not end with collector strobe"); // RULE12

	property p_prog_idle;
		prog_mode && state_r == PCS_ST_FETCH |-> !mem_rd && !irq_ack ##1 state_r == PCS_ST_FETCH;
	endproperty
	a_prog_idle: assert property (p_prog_idle) else $error("fetch while in programming mode"); // RULE16
endmodule // pcs_core

// [dv/pcs_mem_model.sv]
// Byte-wide program/data memory and stack RAM seen by the sequencer.
// Assumes read data is wanted the cycle after a read strobe, and writes land on the strobe's edge.
`timescale 1ns/1ps
module pcs_mem_model (
	input wire logic clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'hff;
		end
		mem_rdata = 8'h00;
	end

	// Data is only good for one cycle; otherwise it toggles so a late sample shows
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			mem_rdata <= mem[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // pcs_mem_model

// [dv/program_counter_sequencer_test.sv]
// Self-checking bench for the program counter sequencer.
// Assumes pcs_core and the memory model; the program is placed in the model during reset.
`timescale 1ns/1ps
`include "pcs_map.svh"
module program_counter_sequencer_test;
	logic clk, nrst, prog_mode, irq_req, irq_ack, irq_exit, mem_rd, mem_wr, ctrl_vld;
	logic [2:0] irq_idx;
	logic [15:0] mem_addr, next_address_counter, call_stack_pointer, loop_a;
	logic [7:0] mem_wdata, mem_rdata, ctrl_dpu, ctrl_dec, ctrl_per, opnd_addr, opnd_aux;
	pcs_pkg::pcs_mode_t addr_mode;
	int err_count, checked;
	logic [7:0] ops [5] = '{8'h00, 8'h01, 8'h22, 8'h53, 8'h64};
	int lens [5] = '{1, 2, 2, 2, 3};
	int dst [5] = '{1, 1, 1, 2, 3};

	pcs_core u_pcs_core (.clk(clk), .nrst(nrst), .prog_mode(prog_mode), .irq_req(irq_req),
		.irq_idx(irq_idx), .irq_ack(irq_ack), .irq_exit(irq_exit), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.next_address_counter(next_address_counter), .call_stack_pointer(call_stack_pointer),
		.ctrl_vld(ctrl_vld), .ctrl_dpu(ctrl_dpu), .ctrl_dec(ctrl_dec), .ctrl_per(ctrl_per),
		.opnd_addr(opnd_addr), .opnd_aux(opnd_aux), .addr_mode(addr_mode));

	pcs_mem_model u_pcs_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic complete_run;
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	// Kind 0 fetch at address a, 1 control pulse, 2 interrupt accept, 3 interrupt exit
	task automatic wait_for(input int which, input logic [15:0] a);
		bit hit;
		hit = 1'b0;
		for (int i = 0; i < 100 && !hit; i++) begin
			@(negedge clk);
			case (which)
				0: hit = (mem_rd === 1'b1 && mem_addr === a);
				1: hit = (ctrl_vld === 1'b1);
				2: hit = (irq_ack === 1'b1);
				default: hit = (irq_exit === 1'b1);
			endcase
		end
		checked++;
		if (!hit) begin
			err_count++;
			$display("wrong value at %0t: event %0d never seen", $time, which);
		end
		if (which == 0) begin
			chk16(next_address_counter, a);
		end
	endtask

	task automatic chk_stack(input logic [15:0] sp, input logic [15:0] ra);
		chk16(call_stack_pointer, sp);
		chk8(u_pcs_mem_model.mem[`PCS_SSP_RESET], ra[15:8]);
		chk8(u_pcs_mem_model.mem[`PCS_SSP_RESET - 16'h0001], ra[7:0]);
	endtask

	// ----------------------------------------
	// Program image and reset
	// ----------------------------------------
	task automatic load_prog;
		logic [15:0] a;
		a = 16'h0100;
		u_pcs_mem_model.mem[0] = `PCS_OP_JP;
		u_pcs_mem_model.mem[1] = 8'h01;
		u_pcs_mem_model.mem[2] = 8'h00;
		for (int i = 0; i < 5; i++) begin
			u_pcs_mem_model.mem[a] = ops[i];
			u_pcs_mem_model.mem[a + 16'h1] = 8'h10 + 8'(i);
			u_pcs_mem_model.mem[a + 16'h2] = 8'h20;
			a = a + 16'(lens[i]);
		end
		u_pcs_mem_model.mem[a] = `PCS_OP_CALL;
		u_pcs_mem_model.mem[a + 16'h1] = 8'h02;
		u_pcs_mem_model.mem[a + 16'h2] = 8'h00;
		loop_a = a + 16'h3;
		u_pcs_mem_model.mem[loop_a] = `PCS_OP_JP;
		u_pcs_mem_model.mem[loop_a + 16'h1] = loop_a[15:8];
		u_pcs_mem_model.mem[loop_a + 16'h2] = loop_a[7:0];
		u_pcs_mem_model.mem[16'h0200] = `PCS_OP_RET;
		u_pcs_mem_model.mem[16'h0009] = `PCS_OP_JP;
		u_pcs_mem_model.mem[16'h000a] = 8'h03;
		u_pcs_mem_model.mem[16'h000b] = 8'h00;
		u_pcs_mem_model.mem[16'h0300] = `PCS_OP_INTERRUPT_EXIT;
	endtask

	task automatic do_reset(input logic pm);
		nrst = 1'b0;
		prog_mode = pm;
		repeat (12) @(negedge clk);
		chk8({7'h00, mem_rd}, 8'h00);
		chk16(next_address_counter, `PCS_RESET_VEC);
		chk16(call_stack_pointer, `PCS_SSP_RESET);
		nrst = 1'b1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// The opcode fetch at the reset vector stands only in the cycle of release
	task automatic chk_first_fetch;
		#2;
		chk8({7'h00, mem_rd}, 8'h01);
		chk16(mem_addr, `PCS_RESET_VEC);
	endtask

	task automatic test_reset;
		do_reset(1'b0);
		chk_first_fetch();
	endtask

	task automatic test_seq;
		logic [15:0] pc;
		pc = 16'h0100;
		wait_for(1, 16'h0);
		chk8(ctrl_dpu, `PCS_OP_JP);
		chk16(next_address_counter, pc);
		for (int i = 0; i < 5; i++) begin
			wait_for(1, 16'h0);
			pc = pc + 16'(lens[i]);
			chk16(next_address_counter, pc);
			chk8({5'h00, addr_mode}, {5'h00, ops[i][2:0]});
			chk8(ctrl_dpu, (dst[i] == 1) ? ops[i] : 8'h00);
			chk8(ctrl_per, (dst[i] == 2) ? ops[i] : 8'h00);
			chk8(ctrl_dec, (dst[i] == 3) ? ops[i] : 8'h00);
			if (lens[i] > 1) begin
				chk8(opnd_addr, 8'h10 + 8'(i));
			end
			if (lens[i] > 2) begin
				chk8(opnd_aux, 8'h20);
			end
		end
	endtask

	task automatic test_call;
		wait_for(0, 16'h0200);
		chk_stack(`PCS_SSP_RESET - `PCS_STACK_STEP, loop_a);
		wait_for(0, loop_a);
		chk16(call_stack_pointer, `PCS_SSP_RESET);
	endtask

	task automatic test_irq;
		irq_idx = 3'h2;
		irq_req = 1'b1;
		// Ack comes in the same fetch cycle; drop the request after the accepting edge
		#1;
		chk8({7'h00, irq_ack}, 8'h01);
		@(negedge clk);
		irq_req = 1'b0;
		wait_for(0, `PCS_VEC_BASE + `PCS_VEC_STRIDE * 16'h2);
		chk_stack(`PCS_SSP_RESET - `PCS_STACK_STEP, loop_a);
		wait_for(0, 16'h0300);
		wait_for(3, 16'h0);
		chk16(next_address_counter, loop_a);
		wait_for(0, loop_a);
		chk16(call_stack_pointer, `PCS_SSP_RESET);
	endtask

	task automatic test_prog;
		do_reset(1'b1);
		repeat (20) begin
			@(negedge clk);
			chk8({7'h00, mem_rd}, 8'h00);
		end
		chk16(next_address_counter, `PCS_RESET_VEC);
		do_reset(1'b0);
		chk_first_fetch();
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		$display("wrong value at %0t: run did not finish", $time);
		complete_run();
	end

	initial begin
		err_count = 0;
		checked = 0;
		nrst = 1'b0;
		prog_mode = 1'b0;
		irq_req = 1'b0;
		irq_idx = 3'h0;
		loop_a = 16'h0000;
		@(negedge clk);
		load_prog();
		test_reset();
		test_seq();
		test_call();
		test_irq();
		test_prog();
		complete_run();
	end
endmodule // program_counter_sequencer_test
